// ==== rtl/spsg_link.sv ====
`timescale 1ns/1ps
// Serial engine on the link clock; one word per request toggle.
module spsg_link (
    // Link clock and reset
    input wire logic link_clk,
    input wire logic nrst,
    // Request from the sequencer, held stable while a toggle is pending
    input wire logic req_tgl,
    input wire spsg_pkg::spsg_req_t req,
    // Answer back to the sequencer
    output logic ack_tgl,
    output logic [31:0] rx_word,
    // Serial pins
    output logic sclk,
    output logic mosi,
    input wire logic miso
);
    logic [1:0] rst_q;
    logic req_s1, req_s2, req_s3;
    logic miso_s1, miso_s2;
    logic busy;
    logic [1:0] phase;
    logic [5:0] cnt;
    logic [31:0] sh;

    always_ff @(posedge link_clk or negedge nrst) begin
        if (!nrst) begin
            rst_q <= 2'b00;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end

    always_ff @(posedge link_clk or negedge rst_q[1]) begin
        if (!rst_q[1]) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_s3 <= 1'b0;
            miso_s1 <= 1'b0;
            miso_s2 <= 1'b0;
        end else begin
            req_s1 <= req_tgl;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
            miso_s1 <= miso;
            miso_s2 <= miso_s1;
        end
    end

    // Each bit takes four link cycles so the synchronised input is settled.
    always_ff @(posedge link_clk or negedge rst_q[1]) begin
        if (!rst_q[1]) begin
            busy <= 1'b0;
            phase <= 2'b00;
            cnt <= 6'h00;
            sh <= 32'h0000_0000;
            rx_word <= 32'h0000_0000;
            ack_tgl <= 1'b0;
            sclk <= 1'b0;
            mosi <= 1'b0;
        end else if (!busy) begin
            sclk <= 1'b0;
            phase <= 2'b00;
            if (req_s2 ^ req_s3) begin
                busy <= 1'b1;
                cnt <= req.nbits;
                sh <= req.word << (6'd32 - req.nbits);
                rx_word <= 32'h0000_0000;
            end
        end else begin
            phase <= phase + 2'b01;
            unique case (phase)
                2'b00: begin
                    sclk <= 1'b0;
                    mosi <= sh[31];
                end
                2'b01: begin
                    sclk <= 1'b0;
                end
                2'b10: begin
                    sclk <= 1'b1;
                end
                2'b11: begin
                    rx_word <= {rx_word[30:0], miso_s2};
                    sh <= {sh[30:0], 1'b0};
                    cnt <= cnt - 6'd1;
                    if (cnt == 6'd1) begin
                        busy <= 1'b0;
                        ack_tgl <= ~ack_tgl;
                    end
                end
            endcase
        end
    end

endmodule

// ==== rtl/spsg_seq.sv ====
`timescale 1ns/1ps
module spsg_seq #(
    parameter int DLEN_W = spsg_pkg::DLEN_W,
    parameter int CONF_LEN_W = spsg_pkg::CONF_LEN_W
) (
    // Clocks and reset
    input wire logic clk,
    input wire logic link_clk,
    input wire logic nrst,
    // Software control
    input wire logic conf_state_enable,
    input wire logic user_transfer_start,
    input wire logic [3:0] segment_magic_field,
    input wire logic segmented_done_irq_enable,
    input wire logic magic_error_clear,
    input wire logic dma_fifo_reset,
    input wire logic buffer_fifo_reset,
    input wire logic receive_fifo_reset,
    // Direct register writes while idle
    input wire logic reg_wr_en,
    input wire logic [3:0] reg_wr_index,
    input wire logic [31:0] reg_wr_data,
    // Transmit DMA stream
    input wire logic tx_valid,
    input wire logic [31:0] tx_data,
    output logic tx_ready,
    // Receive DMA stream
    output logic rx_valid,
    output logic [31:0] rx_data,
    input wire logic rx_ready,
    // Serial pins
    output logic cs_n,
    output logic sclk,
    output logic mosi,
    input wire logic miso,
    // Status
    output logic segmented_done_irq,
    output logic magic_error_raw,
    output logic busy,
    output spsg_pkg::spsg_state_t controller_state,
    output spsg_pkg::spsg_regs_t seg_regs
);

    if (DLEN_W < 6 || DLEN_W > 30) begin : g_bad_dlen
        $error("DLEN_W must lie between 6 and 30");
    end
    if (CONF_LEN_W < 1 || CONF_LEN_W > 30) begin : g_bad_conf_len
        $error("CONF_LEN_W must lie between 1 and 30");
    end

    spsg_pkg::spsg_state_t state;
    spsg_pkg::spsg_state_t next_state;
    logic [31:0] cfg [14];
    logic [13:0] bitmap;
    logic [3:0] ptr;
    logic [CONF_LEN_W:0] gap_cnt;
    logic [DLEN_W:0] bits_left;
    spsg_pkg::spsg_req_t req;
    logic req_tgl;
    logic capture;
    logic ack_tgl;
    logic [31:0] link_rx;
    logic ack_s1, ack_s2, ack_s3;
    logic accept;
    logic rx_take;
    logic ack_evt;
    logic magic_ok;
    logic dout_mode;
    logic din_mode;
    logic use_tx;
    logic use_rx;
    logic seg_next;
    logic need_word;
    logic seg_begin;
    logic fifo_flush;
    logic [CONF_LEN_W:0] gap_last;
    logic [5:0] chunk;

    // Fields of the current segment settings.
    assign dout_mode = cfg[spsg_pkg::BM_USER][spsg_pkg::USER_DOUT_BIT]
        | cfg[spsg_pkg::BM_USER][spsg_pkg::USER_FDX_BIT];
    assign din_mode = cfg[spsg_pkg::BM_USER][spsg_pkg::USER_DIN_BIT]
        | cfg[spsg_pkg::BM_USER][spsg_pkg::USER_FDX_BIT];
    assign use_tx = dout_mode & cfg[spsg_pkg::BM_DMA_CONF][spsg_pkg::DMA_TX_ENA_BIT];
    assign use_rx = capture & cfg[spsg_pkg::BM_DMA_CONF][spsg_pkg::DMA_RX_ENA_BIT];
    assign seg_next = cfg[spsg_pkg::BM_USER][spsg_pkg::USER_NEXT_BIT]
        & conf_state_enable;
    assign gap_last = {1'b0, cfg[spsg_pkg::BM_MISC][CONF_LEN_W-1:0]}
        + (CONF_LEN_W+1)'(spsg_pkg::CS_GAP_EXTRA - 1);

    assign accept = tx_valid & tx_ready;
    assign rx_take = rx_valid & rx_ready;
    assign ack_evt = ack_s2 ^ ack_s3;
    assign fifo_flush = dma_fifo_reset | buffer_fifo_reset | receive_fifo_reset;
    assign magic_ok = tx_data[spsg_pkg::MAGIC_MSB:spsg_pkg::MAGIC_LSB]
        == segment_magic_field;
    assign chunk = (bits_left >= (DLEN_W+1)'(spsg_pkg::WORD_BITS))
        ? 6'd32 : bits_left[5:0];
    assign seg_begin = (next_state == spsg_pkg::ST_XF_LOAD)
        & ((state == spsg_pkg::ST_IDLE) | (state == spsg_pkg::ST_CS_GAP));

    // A word is wanted for the bitmap, for each set bit and for transmit data.
    always_comb begin
        unique case (state)
            spsg_pkg::ST_CONF_MAP: need_word = 1'b1;
            spsg_pkg::ST_CONF_LOAD: need_word = bitmap[ptr];
            spsg_pkg::ST_XF_LOAD: need_word = use_tx & (bits_left != '0);
            default: need_word = 1'b0;
        endcase
    end

    always_comb begin
        next_state = state;
        unique case (state)
            spsg_pkg::ST_IDLE: begin
                if (user_transfer_start) begin
                    if (conf_state_enable) begin
                        next_state = spsg_pkg::ST_CONF_MAP;
                    end else begin
                        next_state = spsg_pkg::ST_XF_LOAD;
                    end
                end
            end
            spsg_pkg::ST_CONF_MAP: begin
                if (accept) begin
                    if (magic_ok) begin
                        next_state = spsg_pkg::ST_CONF_LOAD;
                    end else begin
                        next_state = spsg_pkg::ST_DONE;
                    end
                end
            end
            spsg_pkg::ST_CONF_LOAD: begin
                if (ptr == 4'(spsg_pkg::BM_LAST) && (!bitmap[ptr] || accept)) begin
                    next_state = spsg_pkg::ST_CS_GAP;
                end
            end
            spsg_pkg::ST_CS_GAP: begin
                if (gap_cnt == gap_last) begin
                    next_state = spsg_pkg::ST_XF_LOAD;
                end
            end
            spsg_pkg::ST_XF_LOAD: begin
                if (bits_left == '0) begin
                    if (seg_next) begin
                        next_state = spsg_pkg::ST_CONF_MAP;
                    end else begin
                        next_state = spsg_pkg::ST_DONE;
                    end
                end else if (!use_tx || accept) begin
                    next_state = spsg_pkg::ST_XF_SHIFT;
                end
            end
            spsg_pkg::ST_XF_SHIFT: begin
                if (ack_evt) begin
                    next_state = use_rx ? spsg_pkg::ST_XF_RX : spsg_pkg::ST_XF_LOAD;
                end
            end
            spsg_pkg::ST_XF_RX: begin
                if (rx_take) begin
                    next_state = spsg_pkg::ST_XF_LOAD;
                end
            end
            spsg_pkg::ST_DONE: begin
                next_state = spsg_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= spsg_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Bitmap capture and the walk over its positions.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bitmap <= 14'h0000;
            ptr <= 4'h0;
        end else if (state == spsg_pkg::ST_CONF_MAP) begin
            ptr <= 4'h0;
            if (accept) begin
                bitmap <= tx_data[13:0];
            end
        end else if (state == spsg_pkg::ST_CONF_LOAD) begin
            if (!bitmap[ptr] || accept) begin
                ptr <= ptr + 4'h1;
            end
        end
    end

    // Settings words; reserved positions hold no storage.
    for (genvar i = 0; i < 14; i++) begin : g_cfg
        if (spsg_pkg::BM_VALID_MASK[i]) begin : g_reg
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    cfg[i] <= spsg_pkg::REG_RESET;
                end else if (state == spsg_pkg::ST_CONF_LOAD && accept
                    && ptr == 4'(i)) begin
                    cfg[i] <= tx_data;
                end else if (state == spsg_pkg::ST_IDLE && reg_wr_en
                    && reg_wr_index == 4'(i)) begin
                    cfg[i] <= reg_wr_data;
                end
            end
        end else begin : g_rsv
            assign cfg[i] = spsg_pkg::REG_RESET;
        end
    end

    assign seg_regs = '{
        addr: cfg[spsg_pkg::BM_ADDR],
        ctrl: cfg[spsg_pkg::BM_CTRL],
        clock: cfg[spsg_pkg::BM_CLOCK],
        user: cfg[spsg_pkg::BM_USER],
        user1: cfg[spsg_pkg::BM_USER1],
        user2: cfg[spsg_pkg::BM_USER2],
        dlen: cfg[spsg_pkg::BM_DLEN],
        misc: cfg[spsg_pkg::BM_MISC],
        dma_conf: cfg[spsg_pkg::BM_DMA_CONF],
        dma_int_ena: cfg[spsg_pkg::BM_DMA_INT_ENA],
        dma_int_clr: cfg[spsg_pkg::BM_DMA_INT_CLR]
    };

    // Chip select high time counter of the conf state.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gap_cnt <= '0;
        end else if (state == spsg_pkg::ST_CS_GAP) begin
            gap_cnt <= gap_cnt + (CONF_LEN_W+1)'(1);
        end else begin
            gap_cnt <= '0;
        end
    end

    // Transmit stream handshake; ready drops for at least one cycle after each word.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_ready <= 1'b0;
        end else begin
            tx_ready <= need_word & ~accept & ~fifo_flush;
        end
    end

    // Segment length and word launch towards the link engine.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bits_left <= '0;
            req <= '0;
            req_tgl <= 1'b0;
            capture <= 1'b0;
        end else if (seg_begin) begin
            bits_left <= {1'b0, cfg[spsg_pkg::BM_DLEN][DLEN_W-1:0]}
                + (DLEN_W+1)'(1);
        end else if (state == spsg_pkg::ST_XF_LOAD
            && next_state == spsg_pkg::ST_XF_SHIFT) begin
            req.word <= use_tx ? tx_data : 32'h0000_0000;
            req.nbits <= chunk;
            capture <= din_mode;
            bits_left <= bits_left - (DLEN_W+1)'(chunk);
            req_tgl <= ~req_tgl;
        end
    end

    // Return toggle from the link domain.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
            ack_s3 <= 1'b0;
        end else begin
            ack_s1 <= ack_tgl;
            ack_s2 <= ack_s1;
            ack_s3 <= ack_s2;
        end
    end

    // Receive stream; the word stays until the destination takes it or a fifo reset while idle drops it.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_valid <= 1'b0;
            rx_data <= 32'h0000_0000;
        end else if (state == spsg_pkg::ST_XF_SHIFT && ack_evt && use_rx) begin
            rx_valid <= 1'b1;
            rx_data <= link_rx;
        end else if (rx_take || (fifo_flush && state == spsg_pkg::ST_IDLE)) begin
            rx_valid <= 1'b0;
        end
    end

    // Chip select is low only while segment data moves.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cs_n <= 1'b1;
        end else begin
            cs_n <= ~((next_state == spsg_pkg::ST_XF_LOAD)
                | (next_state == spsg_pkg::ST_XF_SHIFT)
                | (next_state == spsg_pkg::ST_XF_RX));
        end
    end

    // Done pulse and the sticky magic error; a new error beats a clear.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            segmented_done_irq <= 1'b0;
            magic_error_raw <= 1'b0;
        end else begin
            segmented_done_irq <= (state == spsg_pkg::ST_DONE)
                & segmented_done_irq_enable;
            if (state == spsg_pkg::ST_CONF_MAP && accept && !magic_ok) begin
                magic_error_raw <= 1'b1;
            end else if (magic_error_clear) begin
                magic_error_raw <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busy <= 1'b0;
        end else begin
            busy <= next_state != spsg_pkg::ST_IDLE;
        end
    end

    assign controller_state = state;

    spsg_link spsg_link_inst (
        .link_clk(link_clk),
        .nrst(nrst),
        .req_tgl(req_tgl),
        .req(req),
        .ack_tgl(ack_tgl),
        .rx_word(link_rx),
        .sclk(sclk),
        .mosi(mosi),
        .miso(miso)
    );

endmodule

// ==== shared/spsg_pkg.sv ====
package spsg_pkg;

    // Bitmap positions of the reloadable registers.
    localparam int BM_ADDR = 0;
    localparam int BM_CTRL = 1;
    localparam int BM_CLOCK = 2;
    localparam int BM_USER = 3;
    localparam int BM_USER1 = 4;
    localparam int BM_USER2 = 5;
    localparam int BM_DLEN = 6;
    localparam int BM_MISC = 7;
    localparam int BM_DMA_CONF = 11;
    localparam int BM_DMA_INT_ENA = 12;
    localparam int BM_DMA_INT_CLR = 13;
    localparam int BM_LAST = 13;
    localparam logic [13:0] BM_VALID_MASK = 14'h38ff;

    // Magic field inside the bitmap word.
    localparam int MAGIC_MSB = 31;
    localparam int MAGIC_LSB = 28;

    // Fields of the user, length, misc and dma configuration words.
    localparam int USER_FDX_BIT = 0;
    localparam int USER_NEXT_BIT = 1;
    localparam int USER_DIN_BIT = 2;
    localparam int USER_DOUT_BIT = 3;
    localparam int DLEN_W = 18;
    localparam int CONF_LEN_W = 18;
    localparam int DMA_TX_ENA_BIT = 0;
    localparam int DMA_RX_ENA_BIT = 1;

    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam int CS_GAP_EXTRA = 5;
    localparam int WORD_BITS = 32;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CONF_MAP = 3'b001,
        ST_CONF_LOAD = 3'b010,
        ST_CS_GAP = 3'b011,
        ST_XF_LOAD = 3'b100,
        ST_XF_SHIFT = 3'b101,
        ST_XF_RX = 3'b110,
        ST_DONE = 3'b111
    } spsg_state_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] ctrl;
        logic [31:0] clock;
        logic [31:0] user;
        logic [31:0] user1;
        logic [31:0] user2;
        logic [31:0] dlen;
        logic [31:0] misc;
        logic [31:0] dma_conf;
        logic [31:0] dma_int_ena;
        logic [31:0] dma_int_clr;
    } spsg_regs_t;

    typedef struct packed {
        logic [31:0] word;
        logic [5:0] nbits;
    } spsg_req_t;

    function automatic logic bm_valid(input logic [3:0] idx);
        return BM_VALID_MASK[idx];
    endfunction

endpackage

// ==== test/spsg_seq_assertions.sv ====
`timescale 1ns/1ps
module spsg_seq_assertions (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Controls
    input wire logic conf_state_enable,
    input wire logic user_transfer_start,
    input wire logic [3:0] segment_magic_field,
    input wire logic segmented_done_irq_enable,
    input wire logic magic_error_clear,
    // Streams
    input wire logic tx_valid,
    input wire logic [31:0] tx_data,
    input wire logic tx_ready,
    input wire logic rx_valid,
    input wire logic rx_ready,
    // Outputs
    input wire logic cs_n,
    input wire logic segmented_done_irq,
    input wire logic magic_error_raw,
    input wire logic busy,
    input wire spsg_pkg::spsg_state_t controller_state,
    input wire spsg_pkg::spsg_regs_t seg_regs
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [18:0] gap_n;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gap_n <= '0;
        end else if (controller_state == spsg_pkg::ST_CS_GAP) begin
            gap_n <= gap_n + 19'h1;
        end else begin
            gap_n <= '0;
        end
    end
    sequence s_bad_map;
        controller_state == spsg_pkg::ST_CONF_MAP && tx_valid && tx_ready
            && tx_data[31:28] != segment_magic_field;
    endsequence
    sequence s_abort;
        controller_state == spsg_pkg::ST_DONE && magic_error_raw
            ##1 controller_state == spsg_pkg::ST_IDLE && cs_n;
    endsequence
    magic_abort_a: assert property (s_bad_map |=> s_abort)
        else $error("magic mismatch did not end the transfer");
    error_sticky_a: assert property (magic_error_raw && !magic_error_clear
        |=> magic_error_raw)
        else $error("magic error bit dropped without a clear");
    done_after_end_a: assert property (segmented_done_irq |->
        $past(controller_state) == spsg_pkg::ST_DONE && controller_state == spsg_pkg::ST_IDLE)
        else $error("done pulse outside the end of a series");
    done_raised_a: assert property (controller_state == spsg_pkg::ST_DONE
        ##1 controller_state == spsg_pkg::ST_IDLE |-> segmented_done_irq == segmented_done_irq_enable)
        else $error("done pulse missing after the series");
    conf_cs_high_a: assert property (controller_state inside {spsg_pkg::ST_CONF_MAP,
        spsg_pkg::ST_CONF_LOAD, spsg_pkg::ST_CS_GAP} |-> cs_n)
        else $error("chip select low during configuration");
    gap_length_a: assert property ($fell(controller_state == spsg_pkg::ST_CS_GAP) |->
        gap_n == {1'b0, seg_regs.misc[17:0]} + 19'h5)
        else $error("chip select gap has the wrong length");
    tx_spacing_a: assert property (tx_valid && tx_ready |=> !tx_ready)
        else $error("transmit ready held after an accept");
    start_path_a: assert property (controller_state == spsg_pkg::ST_IDLE
        && user_transfer_start
        |=> busy && controller_state == ($past(conf_state_enable) ?
        spsg_pkg::ST_CONF_MAP : spsg_pkg::ST_XF_LOAD))
        else $error("start took the wrong path");
    rx_once_a: assert property (rx_valid && rx_ready |=> !rx_valid)
        else $error("receive word offered twice");
endmodule
bind spsg_seq spsg_seq_assertions spsg_seq_assertions_inst (.clk(clk), .nrst(nrst),
    .conf_state_enable(conf_state_enable), .user_transfer_start(user_transfer_start),
    .segment_magic_field(segment_magic_field), .magic_error_clear(magic_error_clear),
    .segmented_done_irq_enable(segmented_done_irq_enable), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .cs_n(cs_n), .segmented_done_irq(segmented_done_irq), .magic_error_raw(magic_error_raw),
    .busy(busy), .controller_state(controller_state), .seg_regs(seg_regs));

// ==== test/spsg_seq_bench.sv ====
`timescale 1ns/1ps
module spsg_seq_bench;
    localparam logic [31:0] PAT = 32'hC3A5_0F96;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic nrst = 1'b0;
    logic conf_state_enable, user_transfer_start, segmented_done_irq_enable;
    logic magic_error_clear, fifo_rst, reg_wr_en, tx_valid, rx_ready;
    logic [3:0] segment_magic_field, reg_wr_index;
    logic [31:0] reg_wr_data, tx_data, heard;
    logic [31:0] rx_data;
    logic tx_ready, rx_valid, cs_n, sclk, mosi, miso, segmented_done_irq, magic_error_raw, busy;
    spsg_pkg::spsg_state_t controller_state;
    spsg_pkg::spsg_regs_t seg_regs;
    int n_mismatch = 0;
    int n_compared = 0;
    logic [31:0] rxq[$];
    always #50 clk = ~clk;
    always #7.5 link_clk = ~link_clk;
    spsg_seq spsg_seq_inst (.clk(clk), .link_clk(link_clk), .nrst(nrst),
        .conf_state_enable(conf_state_enable), .user_transfer_start(user_transfer_start),
        .segment_magic_field(segment_magic_field), .magic_error_clear(magic_error_clear),
        .segmented_done_irq_enable(segmented_done_irq_enable), .dma_fifo_reset(fifo_rst),
        .buffer_fifo_reset(fifo_rst), .receive_fifo_reset(fifo_rst), .reg_wr_en(reg_wr_en),
        .reg_wr_index(reg_wr_index), .reg_wr_data(reg_wr_data), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready(rx_ready), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso),
        .segmented_done_irq(segmented_done_irq), .magic_error_raw(magic_error_raw),
        .busy(busy), .controller_state(controller_state), .seg_regs(seg_regs));
    spsg_slave spsg_slave_inst (.cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso),
        .heard(heard));
    always @(posedge clk) begin
        if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
            rxq.push_back(rx_data);
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic timed_out();
        n_mismatch++;
        $display("mismatch at %0t: wait ran out", $time);
        close_out();
    endtask
    task automatic reg_wr(input logic [3:0] idx, input logic [31:0] val);
        @(negedge clk);
        reg_wr_en = 1'b1;
        reg_wr_index = idx;
        reg_wr_data = val;
        @(negedge clk);
        reg_wr_en = 1'b0;
    endtask
    // Offers one stream word and holds it until the block takes it.
    task automatic push(input logic [31:0] w);
        int i;
        @(negedge clk);
        tx_valid = 1'b1;
        tx_data = w;
        for (i = 0; i < 2000; i++) begin
            @(posedge clk);
            if (tx_ready === 1'b1) break;
        end
        if (i == 2000) timed_out();
        @(negedge clk);
        tx_valid = 1'b0;
        tx_data = ~w;
    endtask
    task automatic wait_done();
        int i;
        for (i = 0; i < 3000; i++) begin
            @(posedge clk);
            if (segmented_done_irq === 1'b1) break;
        end
        if (i == 3000) timed_out();
    endtask
    task automatic start(input logic conf);
        @(negedge clk);
        conf_state_enable = conf;
        fifo_rst = 1'b1;
        @(negedge clk);
        fifo_rst = 1'b0;
        user_transfer_start = 1'b1;
        @(negedge clk);
        user_transfer_start = 1'b0;
    endtask
    initial begin
        conf_state_enable = 1'b0;
        user_transfer_start = 1'b0;
        segmented_done_irq_enable = 1'b1;
        segment_magic_field = 4'hA;
        magic_error_clear = 1'b0;
        fifo_rst = 1'b0;
        reg_wr_en = 1'b0;
        reg_wr_index = 4'h0;
        reg_wr_data = 32'h0000_0000;
        tx_valid = 1'b0;
        tx_data = 32'h0000_0000;
        rx_ready = 1'b1;
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        reg_wr(4'h1, 32'h0000_0055);
        reg_wr(4'h5, 32'h0000_0077);
        start(1'b1);
        push(32'hA000_09C9);
        push(32'h1111_2222);
        push(32'h0000_0006);
        push(32'h0000_0007);
        push(32'h0000_0003);
        push(32'hFFFF_FFFF);
        push(32'h0000_0002);
        push(32'hA000_0808);
        push(32'h0000_0008);
        push(32'h0000_0001);
        push(32'h0000_005A);
        wait_done();
        chk(seg_regs.addr, 32'h1111_2222);
        chk(seg_regs.ctrl, 32'h0000_0055);
        chk(seg_regs.user2, 32'h0000_0077);
        chk(seg_regs.dlen, 32'h0000_0007);
        chk(seg_regs.misc, 32'h0000_0003);
        chk(seg_regs.dma_conf, 32'h0000_0001);
        chk(32'(rxq.size()), 32'h0000_0001);
        chk(rxq.pop_front(), PAT >> 24);
        chk({24'h00_0000, heard[7:0]}, 32'h0000_005A);
        chk({31'h0, magic_error_raw}, 32'h0000_0000);
        $display("test segmented series done");
        start(1'b1);
        push(32'h5000_0001);
        wait_done();
        chk({31'h0, magic_error_raw}, 32'h0000_0001);
        chk(seg_regs.addr, 32'h1111_2222);
        chk({29'h0, controller_state}, 32'h0000_0000);
        $display("test magic error done");
        reg_wr(4'h3, 32'h0000_0001);
        reg_wr(4'hB, 32'h0000_0003);
        start(1'b0);
        chk({31'h0, magic_error_raw}, 32'h0000_0001);
        push(32'h0000_003C);
        wait_done();
        chk({24'h00_0000, heard[7:0]}, 32'h0000_003C);
        chk(32'(rxq.size()), 32'h0000_0001);
        chk(rxq.pop_front(), PAT >> 24);
        @(negedge clk);
        magic_error_clear = 1'b1;
        @(negedge clk);
        magic_error_clear = 1'b0;
        @(negedge clk);
        chk({31'h0, magic_error_raw}, 32'h0000_0000);
        $display("test single transfer done");
        close_out();
    end
endmodule

// ==== test/spsg_slave.sv ====
`timescale 1ns/1ps
// Serial slave: shifts a fixed pattern out and records what it hears.
module spsg_slave #(
    parameter logic [31:0] PAT = 32'hC3A5_0F96
) (
    // Serial pins
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic mosi,
    output logic miso,
    // Bits heard since chip select fell
    output logic [31:0] heard
);
    logic [31:0] shreg = PAT;
    logic [31:0] heard_q = 32'h0000_0000;
    logic miso_q = 1'b0;
    logic cs_q = 1'b1;
    logic sclk_q = 1'b0;
    assign miso = miso_q;
    assign heard = heard_q;
    // One process owns all slave state, telling the edges apart by the last levels seen.
    always @(cs_n or sclk) begin
        if (cs_n !== cs_q && cs_n === 1'b0) begin
            shreg = PAT;
            heard_q = 32'h0000_0000;
            miso_q = PAT[31];
        end else if (cs_n !== cs_q) begin
            // The line has no pull, so a released line shows the inverse of its last value.
            miso_q = ~miso_q;
        end else if (cs_n === 1'b0 && sclk === 1'b1 && sclk_q === 1'b0) begin
            heard_q = {heard_q[30:0], mosi};
        end else if (cs_n === 1'b0 && sclk === 1'b0 && sclk_q === 1'b1) begin
            shreg = {shreg[30:0], 1'b0};
            miso_q = shreg[31];
        end
        cs_q = cs_n;
        sclk_q = sclk;
    end
endmodule
